// ==== verilog/strap_mode_pkg.sv ====
// Purpose: shared constants and types for the mode strap latch and decoder
// Assumes: 32-bit classic Wishbone register access, byte addresses on adr_i
// Notes:   every offset, field position, code and count used by more than one file

package strap_mode_pkg;

    // strap field
    localparam int          MODE_W          = 5;
    localparam int          SYNC_STAGES     = 2;
    // edges after reset release before the strap is captured (sync depth)
    localparam logic [1:0]  SETTLE_CYCLES   = 2'h2;

    // mode strap codes
    localparam logic [4:0]  CODE_POWER_DOWN = 5'h08;
    localparam logic [4:0]  CODE_RSVD_PD    = 5'h09;
    localparam logic [4:0]  CODE_FORCE_GIG  = 5'h0a;
    localparam logic [4:0]  CODE_FORCE_FAST = 5'h0b;
    localparam logic [4:0]  CODE_RSVD_LO    = 5'h02;
    localparam logic [4:0]  CODE_RSVD_HI    = 5'h07;
    localparam logic [4:0]  CODE_DEF_SINGLE = 5'h18;
    localparam logic [4:0]  CODE_DEF_MULTI  = 5'h19;

    // register byte offsets
    localparam logic [3:0]  STATUS_OFS      = 4'h0;
    localparam logic [3:0]  CONTROL_OFS     = 4'h4;
    localparam logic [3:0]  CONFIG_OFS      = 4'h8;

    // status fields
    localparam int          ST_CODE_LSB     = 0;
    localparam int          ST_VALID_BIT    = 8;
    localparam int          ST_RSVD_BIT     = 9;
    localparam int          ST_PD_BIT       = 10;
    localparam int          ST_MULTI_BIT    = 11;
    localparam int          ST_MODE_LSB     = 12;

    // control fields and reset value
    localparam int          CT_WAKE_BIT     = 0;
    localparam logic        WAKE_RESET      = 1'b0;

    // config readback fields
    localparam int          CF_AN_BIT       = 0;
    localparam int          CF_XOVER_BIT    = 1;
    localparam int          CF_EEE_BIT      = 2;
    localparam int          CF_GFD_BIT      = 3;
    localparam int          CF_GHD_BIT      = 4;
    localparam int          CF_FFD_BIT      = 5;
    localparam int          CF_FHD_BIT      = 6;
    localparam int          CF_TFD_BIT      = 7;
    localparam int          CF_THD_BIT      = 8;
    localparam int          CF_FGIG_BIT     = 9;
    localparam int          CF_FFAST_BIT    = 10;
    localparam int          CF_MASTER_BIT   = 11;
    localparam int          CF_PD_BIT       = 12;
    localparam int          CF_PLL_BIT      = 13;

    typedef enum logic [2:0] {
        MODE_UNCAPTURED = 3'b000,
        MODE_DEFAULT    = 3'b001,
        MODE_POWER_DOWN = 3'b010,
        MODE_FORCE_GIG  = 3'b011,
        MODE_FORCE_FAST = 3'b100,
        MODE_RESERVED   = 3'b101
    } mode_e;

endpackage

// ==== verilog/strap_sync.sv ====
// Purpose: two-stage synchroniser for the strap pins
// Assumes: pins are asynchronous to mclk
// Notes:   first stage is read only by the second stage

`timescale 1ns/1ns

module strap_sync
    import strap_mode_pkg::*;
#(
    parameter int WIDTH = MODE_W
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] meta;

    // one two-flop chain per strap bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic next_meta;
            logic next_synced;
            always_comb begin
                next_meta   = resetn ? pin[i] : 1'b0;
                next_synced = resetn ? meta[i] : 1'b0;
            end
            always_ff @(posedge mclk) begin
                meta[i]   <= next_meta;
                synced[i] <= next_synced;
            end
        end
    endgenerate

endmodule

// ==== verilog/mode_decoder.sv ====
// Purpose: decode the captured mode strap code into port configuration
// Assumes: code is stable once valid is high
// Notes:   purely combinational; the caller registers the results

`timescale 1ns/1ns

module mode_decoder
    import strap_mode_pkg::*;
(
    input  wire logic [MODE_W-1:0] code,
    input  wire logic              valid,
    output mode_e                  mode,
    output logic                   multi_port,
    output logic                   an_enable,
    output logic                   auto_crossover,
    output logic                   eee_enable,
    output logic                   adv_gigabit_full_duplex,
    output logic                   adv_fast_full_duplex,
    output logic                   adv_fast_half,
    output logic                   adv_ten_full,
    output logic                   adv_ten_half,
    output logic                   force_gigabit_full_duplex,
    output logic                   force_fast_full_duplex,
    output logic                   clock_master,
    output logic                   mode_power_down
);

    // one mode per code; safe power-down until the strap is known
    always_comb begin
        mode                      = MODE_UNCAPTURED;
        multi_port                = 1'b0;
        an_enable                 = 1'b0;
        auto_crossover            = 1'b0;
        eee_enable                = 1'b0;
        adv_gigabit_full_duplex   = 1'b0;
        adv_fast_full_duplex      = 1'b0;
        adv_fast_half             = 1'b0;
        adv_ten_full              = 1'b0;
        adv_ten_half              = 1'b0;
        force_gigabit_full_duplex = 1'b0;
        force_fast_full_duplex    = 1'b0;
        clock_master              = 1'b0;
        mode_power_down           = 1'b1;
        if (valid) begin
            case (code) // RQ3
                CODE_POWER_DOWN: begin
                    mode = MODE_POWER_DOWN; // RQ7
                end
                CODE_FORCE_GIG: begin
                    // no negotiation, crossover or eee when forced
                    mode                      = MODE_FORCE_GIG; // RQ8
                    force_gigabit_full_duplex = 1'b1;
                    clock_master              = 1'b1;
                    mode_power_down           = 1'b0;
                end
                CODE_FORCE_FAST: begin
                    mode                   = MODE_FORCE_FAST; // RQ8
                    force_fast_full_duplex = 1'b1;
                    mode_power_down        = 1'b0;
                end
                CODE_RSVD_PD: begin
                    mode = MODE_RESERVED; // RQ9
                end
                default: begin
                    if (code >= CODE_RSVD_LO && code <= CODE_RSVD_HI) begin
                        // reserved test codes keep the ports quiet
                        mode = MODE_RESERVED; // RQ9
                    end else begin
                        // recommended defaults; other codes fall back to them
                        mode                    = MODE_DEFAULT; // RQ6
                        multi_port              = (code == CODE_DEF_MULTI);
                        an_enable               = 1'b1;
                        auto_crossover          = 1'b1;
                        eee_enable              = 1'b1;
                        adv_gigabit_full_duplex = 1'b1;
                        adv_fast_full_duplex    = 1'b1;
                        adv_fast_half           = 1'b1;
                        adv_ten_full            = 1'b1;
                        adv_ten_half            = 1'b1;
                        mode_power_down         = 1'b0;
                    end
                end
            endcase
        end
    end

endmodule

// ==== verilog/strap_mode_latch_decoder.sv ====
// Purpose: latch the mode strap at reset release and drive port configuration
// Assumes: straps held steady by the board before and after reset release
// Notes:   registers on classic Wishbone; software wake releases the strap power-down
//
// Design decisions made here: the register offsets and the Wishbone slave port.

`timescale 1ns/1ns

// What this block does
// RQ1: the strap pins are captured just after reset release and held unchanged afterwards.
// RQ2: the board must keep every strap at its intended level before reset is released.
// RQ3: the captured five-bit code alone selects one defined operating mode for all ports.
// RQ4: gigabit half duplex is never advertised whatever the code.
// RQ5: the board should strap 0x18 for single-port or 0x19 for multi-port systems by default.
// RQ6: codes 0x18 and 0x19 advertise gigabit full, fast full/half, ten full/half with eee.
// RQ7: code 01000 holds the ports in software power-down with the pll still running.
// RQ8: codes 01010 and 01011 force gigabit full as master or fast full, no negotiation.
// RQ9: codes 00010 to 00111 and 01001 are reserved and select no functional mode.
module strap_mode_latch_decoder
    import strap_mode_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic [MODE_W-1:0] mode_strap,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [3:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    output logic                   an_enable,
    output logic                   auto_crossover,
    output logic                   eee_enable,
    output logic                   adv_gigabit_full_duplex,
    output logic                   adv_gigabit_half,
    output logic                   adv_fast_full_duplex,
    output logic                   adv_fast_half,
    output logic                   adv_ten_full,
    output logic                   adv_ten_half,
    output logic                   force_gigabit_full_duplex,
    output logic                   force_fast_full_duplex,
    output logic                   clock_master,
    output logic                   port_power_down,
    output logic                   pll_run
);

    logic [MODE_W-1:0] synced_code;
    logic [MODE_W-1:0] captured_code;
    logic              captured_valid;
    logic [1:0]        settle_cnt;
    logic [MODE_W-1:0] next_captured_code;
    logic              next_captured_valid;
    logic [1:0]        next_settle_cnt;
    logic              wake;
    logic              next_wake;
    mode_e             dec_mode;
    mode_e             mode;
    mode_e             next_mode;
    logic              dec_multi;
    logic              multi_port;
    logic              next_multi_port;
    logic              dec_an;
    logic              dec_xover;
    logic              dec_eee;
    logic              dec_gfd;
    logic              dec_ffd;
    logic              dec_fhd;
    logic              dec_tfd;
    logic              dec_thd;
    logic              dec_fgig;
    logic              dec_ffast;
    logic              dec_master;
    logic              dec_pd;
    logic [13:0]       cfg;
    logic [13:0]       next_cfg;
    logic              access;
    logic [31:0]       next_dat_o;
    logic              next_ack_o;

    strap_sync #(
        .WIDTH (MODE_W)
    ) u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .pin    (mode_strap),
        .synced (synced_code)
    );

    mode_decoder u_dec (
        .code                      (captured_code),
        .valid                     (captured_valid),
        .mode                      (dec_mode),
        .multi_port                (dec_multi),
        .an_enable                 (dec_an),
        .auto_crossover            (dec_xover),
        .eee_enable                (dec_eee),
        .adv_gigabit_full_duplex   (dec_gfd),
        .adv_fast_full_duplex      (dec_ffd),
        .adv_fast_half             (dec_fhd),
        .adv_ten_full              (dec_tfd),
        .adv_ten_half              (dec_thd),
        .force_gigabit_full_duplex (dec_fgig),
        .force_fast_full_duplex    (dec_ffast),
        .clock_master              (dec_master),
        .mode_power_down           (dec_pd)
    );

    // capture once the sync chain holds post-release pin values
    always_comb begin
        next_settle_cnt     = settle_cnt;
        next_captured_code  = captured_code;
        next_captured_valid = captured_valid;
        if (!resetn) begin
            next_settle_cnt     = 2'h0;
            next_captured_code  = '0;
            next_captured_valid = 1'b0;
        end else if (!captured_valid) begin
            if (settle_cnt == SETTLE_CYCLES) begin
                next_captured_code  = synced_code; // RQ1
                next_captured_valid = 1'b1;
            end else begin
                next_settle_cnt = settle_cnt + 2'h1;
            end
        end
        // once valid, nothing reloads the code until the next reset
    end

    always_ff @(posedge mclk) begin
        settle_cnt     <= next_settle_cnt;
        captured_code  <= next_captured_code;
        captured_valid <= next_captured_valid;
    end

    // registered configuration, strap power-down lifted only by software wake
    always_comb begin
        next_mode                     = resetn ? dec_mode : MODE_UNCAPTURED;
        next_multi_port               = resetn & dec_multi;
        next_cfg                      = '0;
        next_cfg[CF_AN_BIT]           = dec_an;
        next_cfg[CF_XOVER_BIT]        = dec_xover;
        next_cfg[CF_EEE_BIT]          = dec_eee;
        next_cfg[CF_GFD_BIT]          = dec_gfd;
        next_cfg[CF_GHD_BIT]          = 1'b0; // RQ4
        next_cfg[CF_FFD_BIT]          = dec_ffd;
        next_cfg[CF_FHD_BIT]          = dec_fhd;
        next_cfg[CF_TFD_BIT]          = dec_tfd;
        next_cfg[CF_THD_BIT]          = dec_thd;
        next_cfg[CF_FGIG_BIT]         = dec_fgig;
        next_cfg[CF_FFAST_BIT]        = dec_ffast;
        next_cfg[CF_MASTER_BIT]       = dec_master;
        // software wake ends the strap power-down, never a reserved one
        next_cfg[CF_PD_BIT]           = dec_pd & ~(wake & (dec_mode == MODE_POWER_DOWN)); // RQ7
        next_cfg[CF_PLL_BIT]          = 1'b1; // RQ7
        if (!resetn) begin
            next_cfg             = '0;
            next_cfg[CF_PD_BIT]  = 1'b1;
            next_cfg[CF_PLL_BIT] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        mode       <= next_mode;
        multi_port <= next_multi_port;
        cfg        <= next_cfg;
    end

    assign an_enable                 = cfg[CF_AN_BIT];
    assign auto_crossover            = cfg[CF_XOVER_BIT];
    assign eee_enable                = cfg[CF_EEE_BIT];
    assign adv_gigabit_full_duplex   = cfg[CF_GFD_BIT];
    assign adv_gigabit_half          = cfg[CF_GHD_BIT];
    assign adv_fast_full_duplex      = cfg[CF_FFD_BIT];
    assign adv_fast_half             = cfg[CF_FHD_BIT];
    assign adv_ten_full              = cfg[CF_TFD_BIT];
    assign adv_ten_half              = cfg[CF_THD_BIT];
    assign force_gigabit_full_duplex = cfg[CF_FGIG_BIT];
    assign force_fast_full_duplex    = cfg[CF_FFAST_BIT];
    assign clock_master              = cfg[CF_MASTER_BIT];
    assign port_power_down           = cfg[CF_PD_BIT];
    assign pll_run                   = cfg[CF_PLL_BIT];

    // wishbone slave: one wait state, ack drops the cycle after it rises
    assign access = cyc_i & stb_i & ~ack_o;

    always_comb begin
        next_wake  = wake;
        next_ack_o = access;
        next_dat_o = '0;
        if (access && !we_i) begin
            case (adr_i[3:2])
                STATUS_OFS[3:2]: begin
                    next_dat_o[ST_CODE_LSB +: MODE_W] = captured_code;
                    next_dat_o[ST_VALID_BIT]          = captured_valid;
                    next_dat_o[ST_RSVD_BIT]           = (mode == MODE_RESERVED);
                    next_dat_o[ST_PD_BIT]             = port_power_down;
                    next_dat_o[ST_MULTI_BIT]          = multi_port;
                    next_dat_o[ST_MODE_LSB +: 3]      = mode;
                end
                CONTROL_OFS[3:2]: begin
                    next_dat_o[CT_WAKE_BIT] = wake;
                end
                CONFIG_OFS[3:2]: begin
                    next_dat_o[13:0] = cfg;
                end
                default: begin
                    next_dat_o = '0; // unmapped reads as zero
                end
            endcase
        end
        if (access && we_i && sel_i[0] && adr_i[3:2] == CONTROL_OFS[3:2]) begin
            next_wake = dat_i[CT_WAKE_BIT];
        end
        if (!resetn) begin
            next_wake  = WAKE_RESET;
            next_ack_o = 1'b0;
            next_dat_o = '0;
        end
    end

    always_ff @(posedge mclk) begin
        wake  <= next_wake;
        ack_o <= next_ack_o;
        dat_o <= next_dat_o;
    end

    // checks
    gig_half_never_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ4
        !adv_gigabit_half)
        else $error("gigabit half duplex advertised");

    capture_time_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ1
        $past(resetn, 1) && $past(resetn, 2) && $past(resetn, 3) |-> captured_valid)
        else $error("strap not captured three edges after release");

    capture_value_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ1
        $rose(captured_valid) |-> captured_code == $past(synced_code))
        else $error("captured code differs from synchronised strap");

    capture_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ1
        captured_valid ##1 captured_valid |-> $stable(captured_code))
        else $error("captured code changed after capture");

    power_down_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ7
        captured_valid && captured_code == CODE_POWER_DOWN && !wake
        |=> port_power_down && pll_run && !an_enable)
        else $error("power-down mode not applied");

    forced_gig_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ8
        captured_valid && captured_code == CODE_FORCE_GIG |=> force_gigabit_full_duplex
        && clock_master && !an_enable && !auto_crossover && !eee_enable && !port_power_down)
        else $error("forced gigabit mode wrong");

    forced_fast_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ8
        captured_valid && captured_code == CODE_FORCE_FAST |=> force_fast_full_duplex
        && !clock_master && !an_enable && !auto_crossover && !eee_enable)
        else $error("forced fast mode wrong");

    default_adv_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ6
        captured_valid && (captured_code == CODE_DEF_SINGLE || captured_code == CODE_DEF_MULTI)
        |=> an_enable && eee_enable && adv_gigabit_full_duplex && adv_fast_full_duplex
        && adv_fast_half && adv_ten_full && adv_ten_half && !port_power_down)
        else $error("default advertisement wrong");

    reserved_mode_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ9
        captured_valid && (captured_code == CODE_RSVD_PD
        || (captured_code >= CODE_RSVD_LO && captured_code <= CODE_RSVD_HI))
        |=> mode == MODE_RESERVED && !an_enable && !force_gigabit_full_duplex)
        else $error("reserved code selected a functional mode");

    single_mode_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ3
        captured_valid |=> mode != MODE_UNCAPTURED
        && !(force_gigabit_full_duplex && force_fast_full_duplex))
        else $error("captured code decoded to no single mode");

    bus_ack_a: assert property (@(posedge mclk) disable iff (!resetn)
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("wishbone ack timing wrong");

    // wake only matters for the strap power-down code
    wake_release_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ7
        captured_valid && captured_code == CODE_POWER_DOWN && wake
        |=> !port_power_down && pll_run)
        else $error("software wake did not lift power-down");

    reserved_wake_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ9
        captured_valid && captured_code == CODE_RSVD_PD |=> port_power_down && !an_enable)
        else $error("reserved code left power-down");

    // first edge after release still shows the safe reset state
    reset_state_a: assert property (@(posedge mclk) disable iff (!resetn) // RQ1
        !$past(resetn) |-> port_power_down && pll_run && !ack_o
        && !an_enable && !captured_valid)
        else $error("outputs not in reset state after release");

    dat_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
        !ack_o |-> dat_o == 32'h0)
        else $error("read data outside acknowledge");

    cover_default_c: cover property (@(posedge mclk) disable iff (!resetn)
        captured_valid && captured_code == CODE_DEF_MULTI);
    cover_force_c: cover property (@(posedge mclk) disable iff (!resetn)
        force_gigabit_full_duplex);
    cover_wake_c: cover property (@(posedge mclk) disable iff (!resetn)
        mode == MODE_POWER_DOWN && $fell(port_power_down));
    cover_reserved_c: cover property (@(posedge mclk) disable iff (!resetn)
        mode == MODE_RESERVED && wake);

endmodule

// ==== verif/strap_board.sv ====
// Purpose: board strap resistors and pin reset source
// Assumes: straps move only when the bench asks for a disturbance
// Notes:   reset is synchronous, so it changes just after a rising edge

`timescale 1ns/1ns

module strap_board (
    input  wire logic       mclk,
    output logic            resetn,
    output logic      [4:0] mode_strap
);
    initial begin
        resetn     = 1'b0;
        mode_strap = 5'h18;
    end

    // straps settle under reset, later the board may misbehave after capture
    task automatic apply(input logic [4:0] code, input logic [4:0] later);
        @(posedge mclk);
        resetn     <= 1'b0;
        mode_strap <= code;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        // held past the capture edge, a late change must be ignored
        repeat (5) @(posedge mclk);
        mode_strap <= later;
    endtask
endmodule

// ==== verif/strap_mode_latch_decoder_bench.sv ====
// Purpose: self-checking bench for the mode strap latch and decoder
// Assumes: wishbone answers within a few cycles of a request
// Notes:   every one of the 32 codes is strapped, then disturbed after capture

`timescale 1ns/1ns

module strap_mode_latch_decoder_bench;
    import strap_mode_pkg::*;
    logic        mclk, resetn, cyc_i, stb_i, we_i, ack_o;
    logic [4:0]  mode_strap;
    logic [3:0]  adr_i, sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic        an, xo, eee, gf, gh, ff, fh, tf, th, fg, fs, cm, pd, pll;
    logic [13:0] cfg_seen;
    int          failures, check_count;

    assign cfg_seen = {pll, pd, cm, fs, fg, th, tf, fh, ff, gh, gf, eee, xo, an};

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    strap_board strap_board_inst (.mclk(mclk), .resetn(resetn), .mode_strap(mode_strap));

    strap_mode_latch_decoder strap_mode_latch_decoder_inst (
        .mclk(mclk), .resetn(resetn), .mode_strap(mode_strap),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .an_enable(an), .auto_crossover(xo), .eee_enable(eee),
        .adv_gigabit_full_duplex(gf), .adv_gigabit_half(gh),
        .adv_fast_full_duplex(ff), .adv_fast_half(fh),
        .adv_ten_full(tf), .adv_ten_half(th),
        .force_gigabit_full_duplex(fg), .force_fast_full_duplex(fs),
        .clock_master(cm), .port_power_down(pd), .pll_run(pll));

    // reference model: config vector in the CONFIG register layout
    function automatic logic [13:0] exp_cfg(input int c);
        logic [13:0] v;
        v = 14'h2000;
        if ((c >= 2 && c <= 9)) v[12] = 1'b1;
        else if (c == 10) v[11:9] = 3'b101;
        else if (c == 11) v[10] = 1'b1;
        else v = v | 14'h01ef;
        return v;
    endfunction

    function automatic logic [31:0] exp_status(input int c);
        int m;
        m = (c == 8) ? 2 : (c == 10) ? 3 : (c == 11) ? 4 : (c >= 2 && c <= 9) ? 5 : 1;
        return 32'(c) | 32'h100 | (32'(m) << 12) | (32'(c == 25) << 11)
               | (32'(exp_cfg(c) >> 12 & 1) << 10) | (32'(m == 5) << 9);
    endfunction

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one classic cycle, entered just after a rising edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            $display("mismatch ack expected 1 seen 0");
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge mclk);
    endtask

    // a control write, then time for wake reg and cfg reg to update
    task automatic wake(input logic [3:0] s, input logic [31:0] d, input logic e, input int c);
        wb(1'b1, CONTROL_OFS, s, d, rd);
        repeat (2) @(posedge mclk);
        check("power down", 32'(e), 32'(pd));
        check("config", 32'(exp_cfg(c) & 14'h2fff) | (32'(e) << 12), 32'(cfg_seen));
    endtask

    task automatic final_report;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge mclk);
        failures++;
        final_report();
    end

    initial begin
        failures    = 0;
        check_count = 0;
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
        rd = $urandom(3964);
        for (int c = 0; c < 32; c++) begin
            strap_board_inst.apply(5'(c), 5'($urandom));
            @(posedge mclk);
            check("config pins", 32'(exp_cfg(c)), 32'(cfg_seen));
            wb(1'b0, CONFIG_OFS, 4'hf, 32'h0, rd);
            check("config reg", 32'(exp_cfg(c)), rd);
            wb(1'b1, STATUS_OFS, 4'hf, $urandom, rd);
            wb(1'b0, STATUS_OFS, 4'hf, 32'h0, rd);
            check("status reg", exp_status(c), rd);
            wb(1'b1, 4'hc, 4'hf, $urandom, rd);
            wb(1'b0, 4'hc, 4'hf, 32'h0, rd);
            check("unmapped", 32'h0, rd);
            if (c == 8 || c == 9) begin
                wb(1'b0, CONTROL_OFS, 4'hf, 32'h0, rd);
                check("control reset", 32'h0, rd);
                wake(4'he, 32'h1, 1'b1, c);
                wake(4'h1, $urandom | 32'h1, (c == 9), c);
                wake(4'h1, 32'h0, 1'b1, c);
            end
        end
        final_report();
    end
endmodule
